// ---- shared/aod_pkg.sv ----
// constants, field layouts and carrier types of the overrange detector
// assumes one 100 MHz clock mclk standing for the sampling clock
// How it works
// - dual samples rising, single samples both edges
// - samples are signed two's complement codes
// - both channels share two programmable thresholds
// - magnitude from upper byte, minimum saturates 127
// - flag set when magnitude reaches threshold
// - dual mode: each channel drives own pins
// - single mode: edge lanes split across pins
// - pulse select gives 8 to 1024 cycles
// - foreground calibration stops sampling entirely
// - background calibration keeps sampling uninterrupted
// - six cores interleaved, swapped for calibration
package aod_pkg;
  localparam int CODE_W = 12;
  localparam int CNT_W = 11;
  localparam logic [10:0] PULSE_BASE = 11'h008;
  localparam logic [7:0] ABS_MIN_CODE = 8'h80;
  localparam logic [6:0] ABS_SAT = 7'h7f;
  localparam logic [2:0] NUM_CORES = 3'h6;
  localparam logic [10:0] FG_CAL_CYCLES = 11'h400;
  localparam logic [7:0] BG_SWAP_CYCLES = 8'hff;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THRESH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // control field positions
  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_BG_EN = 4;
  localparam int CTRL_FG_GO = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] THRESH_RESET = 32'h0000_40e4;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic single_mode;
    logic [2:0] pulse_sel;
    logic bg_en;
    logic [7:0] thr_hi;
    logic [7:0] thr_lo;
  } aod_cfg_s;

  typedef struct packed {
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
  } aod_flags_s;

  typedef enum logic {CAL_IDLE, CAL_FG} aod_cal_e;
endpackage

// ---- rtl/aod_absmag.sv ----
// magnitude of one sample and its two threshold comparisons
// assumes a 12-bit two's complement code from the same clock domain
`timescale 1ns/1ns
module aod_absmag (
  input wire logic [11:0] code,
  input wire logic [7:0] thr_hi,
  input wire logic [7:0] thr_lo,
  output logic [6:0] mag,
  output logic hit_hi,
  output logic hit_lo
);
  logic [7:0] top;
  logic [7:0] neg;
  always_comb begin
    top = code[11:4];
    neg = 8'h00 - top;
    if (top == aod_pkg::ABS_MIN_CODE) begin
      mag = aod_pkg::ABS_SAT;
    end else if (top[7]) begin
      mag = neg[6:0];
    end else begin
      mag = top[6:0];
    end
    // threshold is 8 bits, so the magnitude is left aligned before comparing
    hit_hi = {mag, 1'b0} >= thr_hi;
    hit_lo = {mag, 1'b0} >= thr_lo;
  end
endmodule

// ---- rtl/aod_stretch.sv ----
// stretches one overrange event into a flag of selectable length
// assumes events are single-cycle or level hits on mclk
`timescale 1ns/1ns
module aod_stretch (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] sel,
  input wire logic event_in,
  output logic flag
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic flag_reg;
  always_comb begin
    cnt_next = cnt_reg;
    if (event_in) begin
      cnt_next = aod_pkg::PULSE_BASE << sel;
    end else if (cnt_reg != 11'h000) begin
      cnt_next = cnt_reg - 11'h001;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 11'h000;
      flag_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      flag_reg <= cnt_next != 11'h000;
    end
  end
  assign flag = flag_reg;

  sequence s_quiet8;
    (!event_in && sel == 3'h0)[*8];
  endsequence
  chk_flag_holds: assert property (@(posedge mclk) disable iff (rst) event_in |=> flag[*8])
    else $error("flag dropped before its pulse length");
  chk_flag_ends: assert property (@(posedge mclk) disable iff (rst) event_in ##1 s_quiet8 |=> !flag)
    else $error("flag outlived eight cycles");
  chk_event_restart: assert property (@(posedge mclk) disable iff (rst) event_in |=> cnt_reg == (aod_pkg::PULSE_BASE << $past(sel)))
    else $error("event did not restart counter");
endmodule

// ---- rtl/aod_top.sv ----
// overrange detector with calibration control and an AXI4-Lite register slave
// assumes converted codes arrive on mclk; in single mode lane b is the falling-edge sample
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module aod_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] analog_input_a,
  input wire logic [11:0] analog_input_b,
  output logic [11:0] sample_out_a,
  output logic [11:0] sample_out_b,
  output logic sample_valid,
  output logic chan_a_high_flag_pin,
  output logic chan_a_low_flag_pin,
  output logic chan_b_high_flag_pin,
  output logic chan_b_low_flag_pin,
  output logic irq
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return addr == aod_pkg::OFS_CTRL || addr == aod_pkg::OFS_THRESH || addr == aod_pkg::OFS_STATUS ||
      addr == aod_pkg::OFS_IRQ_STAT || addr == aod_pkg::OFS_IRQ_MASK;
  endfunction

  logic [31:0] ctrl_reg;
  logic [31:0] thresh_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  aod_pkg::aod_cal_e cal_state_reg;
  logic [10:0] cal_cnt_reg;
  logic [7:0] bg_cnt_reg;
  logic [2:0] core_idx_reg;
  logic [11:0] samp_a_reg;
  logic [11:0] samp_b_reg;
  logic valid_reg;
  aod_pkg::aod_cfg_s cfg;
  aod_pkg::aod_flags_s hit;
  aod_pkg::aod_flags_s pins;
  logic do_write;
  logic fg_go;
  logic fg_done;
  logic online;
  logic [2:0] events;
  logic [2:0] irq_clr;
  logic [31:0] status_word;
  logic [6:0] mag_a;
  logic [6:0] mag_b;

  assign cfg.single_mode = ctrl_reg[aod_pkg::CTRL_SINGLE];
  assign cfg.pulse_sel = ctrl_reg[aod_pkg::CTRL_SEL_LSB +: 3];
  assign cfg.bg_en = ctrl_reg[aod_pkg::CTRL_BG_EN];
  assign cfg.thr_hi = thresh_reg[7:0];
  assign cfg.thr_lo = thresh_reg[15:8];

  // write channel: address and data are taken in either order, answered once both are in
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= aod_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? aod_pkg::RESP_OKAY : aod_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // the go bit never stores; it only launches a foreground run
  assign fg_go = do_write && aw_addr_reg == aod_pkg::OFS_CTRL && w_strb_reg[0] && w_data_reg[aod_pkg::CTRL_FG_GO];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= aod_pkg::CTRL_RESET;
      thresh_reg <= aod_pkg::THRESH_RESET;
      irq_mask_reg <= aod_pkg::IRQ_RESET;
    end else if (do_write) begin
      case (aw_addr_reg)
        aod_pkg::OFS_CTRL: begin
          ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_001f;
        end
        aod_pkg::OFS_THRESH: begin
          thresh_reg <= merge(thresh_reg, w_data_reg, w_strb_reg) & 32'h0000_ffff;
        end
        aod_pkg::OFS_IRQ_MASK: begin
          irq_mask_reg <= w_strb_reg[0] ? w_data_reg[2:0] : irq_mask_reg;
        end
        default: begin
        end
      endcase
    end
  end
  // read channel: one answer a cycle after the address is taken
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign status_word = {24'h00_0000, core_idx_reg, cal_state_reg == aod_pkg::CAL_FG, pins};

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= aod_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(s_axi_araddr) ? aod_pkg::RESP_OKAY : aod_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        aod_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
        aod_pkg::OFS_THRESH: rdata_reg <= thresh_reg;
        aod_pkg::OFS_STATUS: rdata_reg <= status_word;
        aod_pkg::OFS_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
        aod_pkg::OFS_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // calibration: foreground stops the converter, background rotates the core under calibration
  assign online = cal_state_reg == aod_pkg::CAL_IDLE;
  assign fg_done = cal_state_reg == aod_pkg::CAL_FG && cal_cnt_reg == aod_pkg::FG_CAL_CYCLES - 11'h001;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_state_reg <= aod_pkg::CAL_IDLE;
      cal_cnt_reg <= 11'h000;
    end else begin
      case (cal_state_reg)
        aod_pkg::CAL_IDLE: begin
          cal_cnt_reg <= 11'h000;
          if (fg_go) begin
            cal_state_reg <= aod_pkg::CAL_FG;
          end
        end
        aod_pkg::CAL_FG: begin
          cal_cnt_reg <= cal_cnt_reg + 11'h001;
          if (fg_done) begin
            cal_state_reg <= aod_pkg::CAL_IDLE;
          end
        end
        default: cal_state_reg <= aod_pkg::CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bg_cnt_reg <= 8'h00;
      core_idx_reg <= 3'h0;
    end else if (cfg.bg_en && online) begin
      bg_cnt_reg <= bg_cnt_reg + 8'h01;
      if (bg_cnt_reg == aod_pkg::BG_SWAP_CYCLES) begin
        // the swapped-out core is calibrated while the other five convert
        core_idx_reg <= (core_idx_reg == aod_pkg::NUM_CORES - 3'h1) ? 3'h0 : core_idx_reg + 3'h1;
      end
    end
  end

  // sample capture; lane b carries channel b in dual mode, the falling edge in single mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      samp_a_reg <= 12'h000;
      samp_b_reg <= 12'h000;
      valid_reg <= 1'b0;
    end else begin
      samp_a_reg <= analog_input_a;
      samp_b_reg <= analog_input_b;
      valid_reg <= online;
    end
  end
  assign sample_out_a = samp_a_reg;
  assign sample_out_b = samp_b_reg;
  assign sample_valid = valid_reg;

  aod_absmag u_abs_a (
    .code(analog_input_a),
    .thr_hi(cfg.thr_hi),
    .thr_lo(cfg.thr_lo),
    .mag(mag_a),
    .hit_hi(hit.a_hi),
    .hit_lo(hit.a_lo)
  );
  aod_absmag u_abs_b (
    .code(analog_input_b),
    .thr_hi(cfg.thr_hi),
    .thr_lo(cfg.thr_lo),
    .mag(mag_b),
    .hit_hi(hit.b_hi),
    .hit_lo(hit.b_lo)
  );

  // each lane feeds its own pin pair in both modes; single mode splits edges across the pairs
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      aod_stretch u_stretch (
        .mclk(mclk),
        .rst(rst),
        .sel(cfg.pulse_sel),
        .event_in(hit[g] && online),
        .flag(pins[g])
      );
    end
  endgenerate
  assign chan_a_high_flag_pin = pins.a_hi;
  assign chan_a_low_flag_pin = pins.a_lo;
  assign chan_b_high_flag_pin = pins.b_hi;
  assign chan_b_low_flag_pin = pins.b_lo;

  // sticky events: high hit, low hit, foreground done; a coincident set beats the clear
  assign events = {fg_done, (hit.a_lo || hit.b_lo) && online, (hit.a_hi || hit.b_hi) && online};
  assign irq_clr = (do_write && aw_addr_reg == aod_pkg::OFS_IRQ_STAT && w_strb_reg[0]) ? w_data_reg[2:0] : 3'h0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_reg <= aod_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | events;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  chk_write_answer: assert property (@(posedge mclk) disable iff (rst)
    (s_aw_taken and s_w_taken) |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after both channels");
  chk_read_answer: assert property (@(posedge mclk) disable iff (rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 (!s_axi_rvalid || $stable(s_axi_rdata)))
    else $error("read not answered in one cycle or data moved while waiting");
  chk_fg_offline: assert property (@(posedge mclk) disable iff (rst)
    fg_go && online |=> !online ##1 (!sample_valid)[*8])
    else $error("sampling continued during foreground calibration");
  chk_fg_length: assert property (@(posedge mclk) disable iff (rst)
    fg_done |=> online ##0 irq_stat_reg[2])
    else $error("foreground run did not end on its count");
  chk_bg_running: assert property (@(posedge mclk) disable iff (rst)
    cfg.bg_en && online |=> sample_valid)
    else $error("background calibration interrupted sampling");
  chk_core_rotate: assert property (@(posedge mclk) disable iff (rst)
    core_idx_reg == 3'h5 && bg_cnt_reg == aod_pkg::BG_SWAP_CYCLES && cfg.bg_en && online |=> core_idx_reg == 3'h0)
    else $error("core index left the six-core ring");
  chk_abs_sat: assert property (@(posedge mclk) disable iff (rst)
    analog_input_a[11:4] == 8'h80 |-> mag_a == 7'h7f)
    else $error("most negative code not saturated");
  chk_abs_neg: assert property (@(posedge mclk) disable iff (rst)
    analog_input_b[11:4] == 8'h90 |-> mag_b == 7'h70)
    else $error("negative code magnitude wrong");
  chk_pin_a_map: assert property (@(posedge mclk) disable iff (rst)
    hit.a_hi && online |=> chan_a_high_flag_pin)
    else $error("channel a high pin missed its hit");
  chk_pin_b_map: assert property (@(posedge mclk) disable iff (rst)
    cfg.single_mode && hit.b_lo && online |=> chan_b_low_flag_pin)
    else $error("falling-edge lane missed its pin");
  chk_irq_set_wins: assert property (@(posedge mclk) disable iff (rst)
    events[0] |=> irq_stat_reg[0])
    else $error("high-hit event lost");
  chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
    irq_stat_reg[1] && irq_mask_reg[1] |-> irq)
    else $error("unmasked status did not raise irq");
endmodule

// ---- sim/aod_monitor.sv ----
// downstream logic model watching the four overrange flag pins
// assumes the pins are sampled on mclk and single_mode mirrors the device mode
`timescale 1ns/1ns
module aod_monitor #(
  parameter logic [7:0] HI_REC = 8'he4,
  parameter logic [7:0] LO_REC = 8'h40,
  parameter int QUIET = 4096
) (
  input wire logic mclk,
  input wire logic single_mode,
  input wire logic a_hi,
  input wire logic a_lo,
  input wire logic b_hi,
  input wire logic b_lo,
  output logic or_hi,
  output logic or_lo,
  output logic raise_gain
);
  int quiet = 0;
  // interleaved lanes report separately, so both pins decide one threshold
  assign or_hi = a_hi | (single_mode & b_hi);
  assign or_lo = a_lo | (single_mode & b_lo);
  always @(posedge mclk) begin
    quiet <= or_lo ? 0 : (quiet < QUIET ? quiet + 1 : quiet);
  end
  assign raise_gain = quiet >= QUIET;
endmodule

// ---- sim/adc_overrange_detector_bench.sv ----
// self-checking bench for the overrange detector top
// assumes aod_top and aod_pkg are compiled first; one 100 MHz clock
`timescale 1ns/1ns
module adc_overrange_detector_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] ca = 12'h000, cb = 12'h000;
  logic single = 1'b0;
  logic [7:0] thr_hi = 8'he4, thr_lo = 8'h40;
  wire awready, wready, bvalid, arready, rvalid, svalid, irq, or_hi, or_lo, raise_gain;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] sa, sb;
  wire [3:0] pins;
  logic [65:0] bus_q[$];
  logic [15:0] pulse_q[$];
  logic [65:0] e_bus;
  logic [15:0] e_pul;
  int fails = 0, checks_done = 0, cyc = 0, lowcnt = 0, base = 0;
  int cnt[4] = '{0, 0, 0, 0};
  integer seed = 32'hfb7f8a9e;
  logic [11:0] tab[5] = '{12'h800, 12'h7f0, 12'h7e0, 12'h900, 12'h000};

  always #5 mclk = ~mclk;

  aod_top aod_top_i (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .analog_input_a(ca),
    .analog_input_b(cb), .sample_out_a(sa), .sample_out_b(sb), .sample_valid(svalid),
    .chan_a_high_flag_pin(pins[0]), .chan_a_low_flag_pin(pins[1]), .chan_b_high_flag_pin(pins[2]),
    .chan_b_low_flag_pin(pins[3]), .irq(irq));

  aod_monitor aod_monitor_i (.mclk(mclk), .single_mode(single), .a_hi(pins[0]), .a_lo(pins[1]),
    .b_hi(pins[2]), .b_lo(pins[3]), .or_hi(or_hi), .or_lo(or_lo), .raise_gain(raise_gain));

  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watcher: every bus answer and every finished flag pulse takes the oldest note
  always @(posedge mclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e_bus = bus_q.size() > 0 ? bus_q.pop_front() : '1;
      if (bvalid) check({bresp, 32'h0}, e_bus[33:0]);
      else check({rresp, rdata & e_bus[65:34]}, {e_bus[33:32], e_bus[31:0] & e_bus[65:34]});
    end
    for (int i = 0; i < 4; i++) begin
      if (pins[i]) begin
        cnt[i]++;
      end else if (cnt[i] > 0) begin
        e_pul = pulse_q.size() > 0 ? pulse_q.pop_front() : 16'hffff;
        check(66'({i[1:0], 14'(cnt[i])}), 66'(e_pul));
        cnt[i] = 0;
      end
    end
    if (!svalid && !rst) lowcnt <= lowcnt + 1;
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bus_q.push_back({32'h0, er, 32'h0});
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                          input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    bus_q.push_back({m, er, d});
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  function automatic logic hit(input logic [11:0] c, input logic [7:0] t);
    logic [7:0] u;
    logic [6:0] m;
    u = c[11:4];
    m = !u[7] ? u[6:0] : (u == 8'h80 ? 7'h7f : 7'(-u));
    return {m, 1'b0} >= t;
  endfunction

  task automatic set_thr(input logic [7:0] h, input logic [7:0] l);
    thr_hi = h;
    thr_lo = l;
    axi_write(aod_pkg::OFS_THRESH, {16'h0, l, h}, aod_pkg::RESP_OKAY);
  endtask

  task automatic set_ctrl(input logic s, input logic [2:0] sel, input logic bg);
    single = s;
    axi_write(aod_pkg::OFS_CTRL, {27'h0, bg, sel, s}, aod_pkg::RESP_OKAY);
  endtask

  // one sample pair for one cycle; live is low while sampling is halted
  task automatic fire(input logic [11:0] a, input logic [11:0] b, input logic [2:0] sel, input logic live);
    logic [3:0] h;
    h = {hit(b, thr_lo), hit(b, thr_hi), hit(a, thr_lo), hit(a, thr_hi)};
    for (int i = 0; i < 4; i++) if (h[i] && live) pulse_q.push_back({i[1:0], 14'(8 << sel)});
    @(posedge mclk);
    ca <= a;
    cb <= b;
    @(posedge mclk);
    ca <= 12'h000;
    cb <= 12'h000;
    @(posedge mclk);
    if (live) check(66'({sa, sb}), 66'({a, b}));
    repeat ((8 << sel) + 4) @(posedge mclk);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    axi_read(aod_pkg::OFS_CTRL, '1, 32'h0, aod_pkg::RESP_OKAY);
    axi_read(aod_pkg::OFS_THRESH, '1, {16'h0, aod_monitor_i.LO_REC, aod_monitor_i.HI_REC},
             aod_pkg::RESP_OKAY);
    axi_read(aod_pkg::OFS_IRQ_MASK, '1, 32'h0, aod_pkg::RESP_OKAY);
    axi_read(8'h14, '1, 32'h0, aod_pkg::RESP_SLVERR);
    axi_write(8'h18, 32'h1, aod_pkg::RESP_SLVERR);
    $display("test registers done");
    set_thr(8'hfe, 8'hfc);
    for (int i = 0; i < 5; i++) fire(tab[i], tab[4 - i], 3'h0, 1'b1);
    for (int i = 0; i < 24; i++) begin
      if (i % 8 == 0) set_thr(8'($random(seed)) | 8'h01, 8'($random(seed)) | 8'h01);
      fire(12'($random(seed)), 12'($random(seed)), 3'h0, 1'b1);
    end
    $display("test magnitude done");
    set_thr(aod_monitor_i.HI_REC, aod_monitor_i.LO_REC);
    for (int s = 0; s < 8; s++) begin
      set_ctrl(1'b0, 3'(s), 1'b0);
      fire(12'h7f0, 12'h000, 3'(s), 1'b1);
    end
    set_ctrl(1'b0, 3'h0, 1'b0);
    pulse_q.push_back({2'd0, 14'd11});
    pulse_q.push_back({2'd1, 14'd11});
    @(posedge mclk);
    ca <= 12'h7f0;
    @(posedge mclk);
    ca <= 12'h000;
    repeat (2) @(posedge mclk);
    ca <= 12'h7f0;
    @(posedge mclk);
    ca <= 12'h000;
    repeat (16) @(posedge mclk);
    $display("test length done");
    set_ctrl(1'b1, 3'h0, 1'b0);
    pulse_q.push_back({2'd2, 14'd8});
    pulse_q.push_back({2'd3, 14'd8});
    @(posedge mclk);
    cb <= 12'h800;
    @(posedge mclk);
    cb <= 12'h000;
    @(posedge mclk);
    check(66'({or_hi, or_lo}), 66'h3);
    repeat (12) @(posedge mclk);
    $display("test single done");
    set_ctrl(1'b0, 3'h0, 1'b0);
    base = lowcnt;
    axi_write(aod_pkg::OFS_CTRL, 32'h20, aod_pkg::RESP_OKAY);
    axi_read(aod_pkg::OFS_STATUS, 32'h10, 32'h10, aod_pkg::RESP_OKAY);
    fire(12'h800, 12'h800, 3'h0, 1'b0);
    repeat (1100) @(posedge mclk);
    check(66'(lowcnt - base >= 1024 && lowcnt - base <= 1026), 66'h1);
    check(66'(irq), 66'h0);
    axi_read(aod_pkg::OFS_IRQ_STAT, 32'h7, 32'h7, aod_pkg::RESP_OKAY);
    axi_write(aod_pkg::OFS_IRQ_MASK, 32'h7, aod_pkg::RESP_OKAY);
    @(posedge mclk);
    check(66'(irq), 66'h1);
    axi_write(aod_pkg::OFS_IRQ_STAT, 32'h7, aod_pkg::RESP_OKAY);
    @(posedge mclk);
    check(66'(irq), 66'h0);
    axi_read(aod_pkg::OFS_IRQ_STAT, 32'h7, 32'h0, aod_pkg::RESP_OKAY);
    $display("test calibration done");
    set_ctrl(1'b0, 3'h0, 1'b1);
    base = lowcnt;
    fire(12'h7f0, 12'h000, 3'h0, 1'b1);
    // long enough for the core index to wrap from the last core back to the first
    repeat (1700) @(posedge mclk);
    check(66'(lowcnt - base), 66'h0);
    check(66'(irq), 66'h1);
    $display("test background done");
    check(66'(bus_q.size() + pulse_q.size()), 66'h0);
    report_and_stop();
  end
endmodule
